// *** src/data_memory_map.sv ***
`timescale 1ns/10ps
`include "data_map_defs.svh"
module data_memory_map #(
    parameter int unsigned PROG_BYTES  = `PROG_BYTES_DEF,
    parameter logic [15:0] DFLASH_BASE = `DFLASH_BASE_DEF
) (
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    // Decoder requests and answers
    input  wire data_map_pkg::req_t     req,
    output logic                        req_ready,
    output data_map_pkg::rsp_t          rsp,
    // Opcode stream
    input  wire logic                   opcode_valid,
    input  wire logic [7:0]             opcode,
    // ALU results
    input  wire data_map_pkg::alu_upd_t alu_upd,
    // Flash read path
    input  wire logic [15:0]            fetch_pc,
    output logic [15:0]                 flash_addr,
    output logic                        flash_prog_sel,
    output logic                        flash_data_sel,
    input  wire logic [7:0]             flash_rdata,
    // Register views
    output logic [7:0]                  primary_operand,
    output logic [7:0]                  muldiv_operand,
    output logic [7:0]                  flags,
    output logic [7:0]                  stack_top,
    output logic [15:0]                 data_pointer_pair
);
    import data_map_pkg::*;

    if (PROG_BYTES != `PROG_BYTES_DEF && PROG_BYTES != `PROG_BYTES_ALT)
    begin : g_chk
        $error("data_memory_map: program flash must be 4K or 2K");
    end

    state_t      state_q, state_d;
    op_t         op_q;
    logic [7:0]  stack_top_ptr_q;
    logic [15:0] ptr_pair_q [2];
    logic        pointer_select_q;
    logic [7:1]  alu_flags_q;
    logic [7:0]  primary_operand_q;
    logic [7:0]  muldiv_operand_q;
    logic [7:0]  byte_q, wdata_q, ret_hi_q, hold_q;
    logic [2:0]  idx_q;
    logic        wbit_q, sfr_q;
    logic        rsp_valid_q, rsp_bit_q;
    logic [7:0]  rsp_data_q;
    logic [15:0] flash_addr_q;
    logic        flash_psel_q, flash_dsel_q;

    logic        take, is_bit, tgt_sfr, sfr_we;
    logic [7:0]  tgt, ptr_reg, sfr_wdata, rd_byte;
    logic [1:0]  bank;
    logic        ram_we;
    logic [7:0]  ram_waddr, ram_wdata, ram_raddr, ram_rdata;
    logic [15:0] code_addr_d;

    function automatic logic [7:0] put_bit(input logic [7:0] v,
                                           input logic [2:0] i,
                                           input logic       x);
        logic [7:0] r;
        r = v;
        r[i] = x;
        return r;
    endfunction

    function automatic logic sfr_hit(input logic [7:0] a);
        case (a)
            `SFR_STACK_TOP_PTR, `SFR_DATA_PTR_LOW, `SFR_DATA_PTR_HIGH,
            `SFR_AUX_CONTROL_TWO, `SFR_ALU_FLAGS_WORD,
            `SFR_PRIMARY_OPERAND, `SFR_MULDIV_OPERAND: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // Flags word with parity always tracking the primary operand
    assign flags = {alu_flags_q[7:1], ^primary_operand_q};
    assign bank  = {alu_flags_q[`FLAG_BANK_HIGH_BIT],
                    alu_flags_q[`FLAG_BANK_LOW_BIT]};
    assign data_pointer_pair = ptr_pair_q[pointer_select_q];

    function automatic logic [7:0] sfr_value(input logic [7:0] a);
        case (a)
            `SFR_STACK_TOP_PTR:   return stack_top_ptr_q;
            `SFR_DATA_PTR_LOW:    return data_pointer_pair[7:0];
            `SFR_DATA_PTR_HIGH:   return data_pointer_pair[15:8];
            `SFR_AUX_CONTROL_TWO: return {7'h00, pointer_select_q};
            `SFR_ALU_FLAGS_WORD:  return flags;
            `SFR_PRIMARY_OPERAND: return primary_operand_q;
            `SFR_MULDIV_OPERAND:  return muldiv_operand_q;
            default:              return `UNMAPPED_READ;
        endcase
    endfunction

    assign take      = req.valid && (state_q == st_idle);
    assign req_ready = (state_q == st_idle);
    assign is_bit    = (req.op == op_bit_rd) || (req.op == op_bit_wr);

    // Target byte from the operation type, the address and the register bank
    always_comb begin
        if (is_bit) begin
            tgt = req.addr[7] ? {req.addr[7:3], 3'b000}
                              : (`RAM_BIT_BASE | {4'h0, req.addr[6:3]});
        end else if (req.op == op_reg_rd || req.op == op_reg_wr) begin
            tgt = {3'b000, bank, req.addr[2:0]};
        end else begin
            tgt = req.addr;
        end
        ptr_reg = {3'b000, bank, 2'b00, req.addr[0]};
        // Only direct and bit forms ever reach the SFR space
        tgt_sfr = tgt[7] && (is_bit || req.op == op_dir_rd
                             || req.op == op_dir_wr);
    end

    // SFR writes: unassigned addresses match no register below
    always_comb begin
        sfr_we    = 1'b0;
        sfr_wdata = req.wdata;
        if (take && tgt_sfr) begin
            if (req.op == op_dir_wr) begin
                sfr_we = 1'b1;
            end else if (req.op == op_bit_wr && sfr_hit(tgt)) begin
                sfr_we    = 1'b1;
                sfr_wdata = put_bit(sfr_value(tgt), req.addr[2:0], req.wbit);
            end
        end
    end

    // Scratch-pad ports
    always_comb begin
        ram_we    = 1'b0;
        ram_waddr = tgt;
        ram_wdata = req.wdata;
        ram_raddr = byte_q;
        case (state_q)
            st_idle: begin
                ram_raddr = tgt;
                if (take) begin
                    case (req.op)
                        op_dir_wr, op_reg_wr: ram_we = !tgt_sfr;
                        op_ind_rd, op_ind_wr: ram_raddr = ptr_reg;
                        op_push: begin
                            ram_we    = 1'b1;
                            ram_waddr = stack_top_ptr_q + 8'h01;
                        end
                        op_call: begin
                            ram_we    = 1'b1;
                            ram_waddr = stack_top_ptr_q + 8'h01;
                            ram_wdata = req.ret_addr[7:0];
                        end
                        op_pop:  ram_raddr = stack_top_ptr_q;
                        default: ram_raddr = tgt;
                    endcase
                end
            end
            st_ptr: begin
                // Pointer byte reaches the whole 256 bytes, upper half too
                ram_raddr = ram_rdata;
                ram_waddr = ram_rdata;
                ram_wdata = wdata_q;
                ram_we    = (op_q == op_ind_wr);
            end
            st_bitwr: begin
                ram_we    = 1'b1;
                ram_waddr = byte_q;
                ram_wdata = put_bit(ram_rdata, idx_q, wbit_q);
            end
            st_push_hi: begin
                ram_we    = 1'b1;
                ram_waddr = stack_top_ptr_q + 8'h01;
                ram_wdata = ret_hi_q;
            end
            default: ram_raddr = byte_q;
        endcase
    end

    scratch_ram #(
        .DEPTH (`RAM_BYTES),
        .WIDTH (8)
    ) u_ram (
        .clk_sys (clk_sys),
        .we      (ram_we),
        .waddr   (ram_waddr),
        .wdata   (ram_wdata),
        .raddr   (ram_raddr),
        .rdata_q (ram_rdata)
    );

    // Sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            st_idle: begin
                if (take) begin
                    case (req.op)
                        op_ind_rd, op_ind_wr: state_d = st_ptr;
                        op_bit_wr: state_d = tgt_sfr ? st_data : st_bitwr;
                        op_call:    state_d = st_push_hi;
                        op_code_rd: state_d = st_flash;
                        default:    state_d = st_data;
                    endcase
                end
            end
            st_ptr, st_bitwr, st_push_hi, st_flash: state_d = st_data;
            st_data: state_d = st_idle;
            default: state_d = st_idle;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= st_idle;
        end else begin
            state_q <= state_d;
        end
    end

    // Request capture
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            op_q     <= op_dir_rd;
            byte_q   <= 8'h00;
            idx_q    <= 3'h0;
            wdata_q  <= 8'h00;
            wbit_q   <= 1'b0;
            ret_hi_q <= 8'h00;
            sfr_q    <= 1'b0;
            hold_q   <= 8'h00;
        end else if (take) begin
            op_q     <= req.op;
            byte_q   <= tgt;
            idx_q    <= req.addr[2:0];
            wdata_q  <= req.wdata;
            wbit_q   <= req.wbit;
            ret_hi_q <= req.ret_addr[15:8];
            sfr_q    <= tgt_sfr;
            hold_q   <= sfr_value(tgt);
        end
    end

    // Answer
    assign rd_byte = (op_q == op_code_rd) ? flash_rdata
                   : sfr_q ? hold_q : ram_rdata;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= 8'h00;
            rsp_bit_q   <= 1'b0;
        end else begin
            rsp_valid_q <= (state_q == st_data);
            if (state_q == st_data) begin
                rsp_data_q <= rd_byte;
                rsp_bit_q  <= rd_byte[idx_q];
            end
        end
    end

    assign rsp = '{valid: rsp_valid_q, rdata: rsp_data_q, rbit: rsp_bit_q};

    // Stack top pointer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stack_top_ptr_q <= `STACK_TOP_RESET;
        end else if (sfr_we && tgt == `SFR_STACK_TOP_PTR) begin
            stack_top_ptr_q <= sfr_wdata;
        end else if ((take && (req.op == op_push || req.op == op_call))
                     || state_q == st_push_hi) begin
            stack_top_ptr_q <= stack_top_ptr_q + 8'h01;
        end else if (take && req.op == op_pop) begin
            stack_top_ptr_q <= stack_top_ptr_q - 8'h01;
        end
    end
    assign stack_top = stack_top_ptr_q;

    // Dual data pointers
    for (genvar g = 0; g < 2; g++) begin : g_pair
        logic mine;
        assign mine = (pointer_select_q == 1'(g));
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                ptr_pair_q[g] <= `DATA_PTR_RESET;
            end else if (mine && sfr_we && tgt == `SFR_DATA_PTR_LOW) begin
                ptr_pair_q[g][7:0] <= sfr_wdata;
            end else if (mine && sfr_we && tgt == `SFR_DATA_PTR_HIGH) begin
                ptr_pair_q[g][15:8] <= sfr_wdata;
            end else if (mine && opcode_valid
                         && opcode == `POINTER_DEC_OPCODE) begin
                ptr_pair_q[g] <= ptr_pair_q[g] - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pointer_select_q <= `AUX_CONTROL_RESET;
        end else if (sfr_we && tgt == `SFR_AUX_CONTROL_TWO) begin
            pointer_select_q <= sfr_wdata[`POINTER_SELECT_BIT];
        end
    end

    // Flags word; a register write wins over an ALU update
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            alu_flags_q <= `ALU_FLAGS_RESET;
        end else if (sfr_we && tgt == `SFR_ALU_FLAGS_WORD) begin
            alu_flags_q <= sfr_wdata[7:1];
        end else if (alu_upd.flag_we) begin
            alu_flags_q[`FLAG_CARRY_BIT]     <= alu_upd.cy;
            alu_flags_q[`FLAG_AUX_CARRY_BIT] <= alu_upd.ac;
            alu_flags_q[`FLAG_OVERFLOW_BIT]  <= alu_upd.ov;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            primary_operand_q <= `PRIMARY_RESET;
        end else if (sfr_we && tgt == `SFR_PRIMARY_OPERAND) begin
            primary_operand_q <= sfr_wdata;
        end else if (alu_upd.primary_we) begin
            primary_operand_q <= alu_upd.primary;
        end
    end
    assign primary_operand = primary_operand_q;

    // Second multiply/divide operand, general purpose otherwise
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            muldiv_operand_q <= `MULDIV_RESET;
        end else if (sfr_we && tgt == `SFR_MULDIV_OPERAND) begin
            muldiv_operand_q <= sfr_wdata;
        end else if (alu_upd.muldiv_we) begin
            muldiv_operand_q <= alu_upd.muldiv;
        end
    end
    assign muldiv_operand = muldiv_operand_q;

    // Flash address: fetch address, loaded only while idle, unless a code read owns the port
    assign code_addr_d = (take && req.op == op_code_rd)
                       ? data_pointer_pair + {8'h00, primary_operand_q}
                       : fetch_pc;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flash_addr_q <= 16'h0000;
            flash_psel_q <= 1'b0;
            flash_dsel_q <= 1'b0;
        end else if (state_q == st_idle) begin
            flash_addr_q <= code_addr_d;
            flash_psel_q <= {1'b0, code_addr_d} < 17'(PROG_BYTES);
            flash_dsel_q <= ({1'b0, code_addr_d} >= {1'b0, DFLASH_BASE})
                && ({1'b0, code_addr_d}
                    < ({1'b0, DFLASH_BASE} + `DFLASH_BYTES));
        end
    end

    assign flash_addr     = flash_addr_q;
    assign flash_prog_sel = flash_psel_q;
    assign flash_data_sel = flash_dsel_q;
endmodule

// *** src/data_map_defs.svh ***
`ifndef DATA_MAP_DEFS_SVH
`define DATA_MAP_DEFS_SVH

// Special function register addresses
`define SFR_BASE            8'h80
`define SFR_STACK_TOP_PTR   8'h81
`define SFR_DATA_PTR_LOW    8'h82
`define SFR_DATA_PTR_HIGH   8'h83
`define SFR_AUX_CONTROL_TWO 8'ha3
`define SFR_ALU_FLAGS_WORD  8'hd0
`define SFR_PRIMARY_OPERAND 8'he0
`define SFR_MULDIV_OPERAND  8'hf0

// Reset values and the value read from unassigned SFR addresses
`define STACK_TOP_RESET     8'h07
`define DATA_PTR_RESET      16'h0000
`define AUX_CONTROL_RESET   1'b0
`define ALU_FLAGS_RESET     7'h00
`define PRIMARY_RESET       8'h00
`define MULDIV_RESET        8'h00
`define UNMAPPED_READ       8'h00

// Field positions
`define POINTER_SELECT_BIT  0
`define FLAG_CARRY_BIT      7
`define FLAG_AUX_CARRY_BIT  6
`define FLAG_BANK_HIGH_BIT  4
`define FLAG_BANK_LOW_BIT   3
`define FLAG_OVERFLOW_BIT   2
`define FLAG_PARITY_BIT     0

// Bit-addressable scratch-pad area
`define RAM_BIT_BASE        8'h20

// Opcodes
`define POINTER_DEC_OPCODE  8'ha5

// Flash geometry
`define PROG_BYTES_DEF      4096
`define PROG_BYTES_ALT      2048
`define DFLASH_BYTES        17'd128
`define DFLASH_PAGE_BYTES   16
`define DFLASH_BASE_DEF     16'hf000

// Scratch-pad size
`define RAM_BYTES           256

`endif

// *** src/data_map_pkg.sv ***
package data_map_pkg;

    typedef enum logic [3:0] {
        op_dir_rd   = 4'h0,
        op_dir_wr   = 4'h1,
        op_ind_rd   = 4'h2,
        op_ind_wr   = 4'h3,
        op_reg_rd   = 4'h4,
        op_reg_wr   = 4'h5,
        op_bit_rd   = 4'h6,
        op_bit_wr   = 4'h7,
        op_push     = 4'h8,
        op_pop      = 4'h9,
        op_call     = 4'ha,
        op_code_rd  = 4'hb
    } op_t;

    typedef enum logic [5:0] {
        st_idle    = 6'b000001,
        st_ptr     = 6'b000010,
        st_bitwr   = 6'b000100,
        st_push_hi = 6'b001000,
        st_flash   = 6'b010000,
        st_data    = 6'b100000
    } state_t;

    typedef struct packed {
        logic        valid;
        op_t         op;
        logic [7:0]  addr;
        logic [7:0]  wdata;
        logic        wbit;
        logic [15:0] ret_addr;
    } req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
        logic       rbit;
    } rsp_t;

    typedef struct packed {
        logic       primary_we;
        logic [7:0] primary;
        logic       muldiv_we;
        logic [7:0] muldiv;
        logic       flag_we;
        logic       cy;
        logic       ac;
        logic       ov;
    } alu_upd_t;

endpackage

// *** src/scratch_ram.sv ***
`timescale 1ns/10ps
module scratch_ram #(
    parameter int unsigned DEPTH = 256,
    parameter int unsigned WIDTH = 8
) (
    // Clock
    input  wire logic                     clk_sys,
    // Write port
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] waddr,
    input  wire logic [WIDTH-1:0]         wdata,
    // Read port
    input  wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic      [WIDTH-1:0]         rdata_q
);
    logic [WIDTH-1:0] mem [DEPTH];

    if (DEPTH < 2 || WIDTH < 1) begin : g_chk
        $error("scratch_ram: bad geometry");
    end

    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read of a location written in the same cycle returns the old byte
    always_ff @(posedge clk_sys) begin
        rdata_q <= mem[raddr];
    end
endmodule

// *** dv/data_memory_map_properties.sv ***
`timescale 1ns/10ps
module data_memory_map_properties #(
    parameter int unsigned PROG_BYTES  = 4096,
    parameter logic [15:0] DFLASH_BASE = 16'hf000
) (
    // Clock and reset
    input wire logic               clk_sys,
    input wire logic               rst,
    // Requests and answers
    input wire data_map_pkg::req_t req,
    input wire logic               req_ready,
    input wire data_map_pkg::rsp_t rsp,
    input wire logic               opcode_valid,
    input wire logic [7:0]         opcode,
    // Flash and register views
    input wire logic [15:0]        fetch_pc,
    input wire logic [15:0]        flash_addr,
    input wire logic               flash_prog_sel,
    input wire logic               flash_data_sel,
    input wire logic [7:0]         flash_rdata,
    input wire logic [7:0]         primary_operand,
    input wire logic [7:0]         flags,
    input wire logic [7:0]         stack_top,
    input wire logic [15:0]        data_pointer_pair
);
    import data_map_pkg::*;
    logic take;
    assign take = req.valid && req_ready;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_stack_reset_value: assert property (
        $past(rst) |-> stack_top == 8'h07) else $error("stack not 07h");
    a_push_incr_first: assert property (
        take && req.op == op_push |-> ##2
        stack_top == $past(stack_top, 2) + 8'h01) else $error("push stack");
    a_pop_decr_after: assert property (
        take && req.op == op_pop |-> ##2
        stack_top == $past(stack_top, 2) - 8'h01) else $error("pop stack");
    a_call_two_bytes: assert property (
        take && req.op == op_call |-> ##3
        stack_top == $past(stack_top, 3) + 8'h02) else $error("call stack");
    a_direct_answer: assert property (
        take && req.op inside {op_dir_rd, op_dir_wr, op_push, op_pop}
        |=> !rsp.valid ##1 rsp.valid) else $error("direct latency");
    a_indirect_answer: assert property (
        take && req.op inside {op_ind_rd, op_ind_wr, op_call}
        |=> !rsp.valid [*2] ##1 rsp.valid) else $error("indirect latency");
    a_code_read_path: assert property (
        take && req.op == op_code_rd |=> flash_addr ==
        $past(data_pointer_pair) + {8'h00, $past(primary_operand)} ##2
        rsp.valid && rsp.rdata == $past(flash_rdata))
        else $error("code read path");
    a_ptr_decrement: assert property (
        opcode_valid && opcode == 8'ha5 && req_ready && !req.valid
        |=> data_pointer_pair == $past(data_pointer_pair) - 16'h0001)
        else $error("pointer decrement");
    a_parity_flag: assert property (
        flags[0] == ^primary_operand) else $error("parity flag");
    a_fetch_follow: assert property (
        !rst && req_ready && !req.valid |=> flash_addr == $past(fetch_pc))
        else $error("fetch address");
    a_prog_select: assert property (
        !$past(rst) |-> flash_prog_sel == ({16'h0000, flash_addr} < PROG_BYTES))
        else $error("program select");
    a_data_select: assert property (
        !$past(rst) |-> flash_data_sel == (flash_addr >= DFLASH_BASE
        && {1'b0, flash_addr} < {1'b0, DFLASH_BASE} + 17'd128))
        else $error("data select");
endmodule

bind data_memory_map data_memory_map_properties #(
    .PROG_BYTES (PROG_BYTES),
    .DFLASH_BASE(DFLASH_BASE)
) u_props (
    .clk_sys(clk_sys), .rst(rst), .req(req), .req_ready(req_ready),
    .rsp(rsp), .opcode_valid(opcode_valid), .opcode(opcode),
    .fetch_pc(fetch_pc), .flash_addr(flash_addr),
    .flash_prog_sel(flash_prog_sel), .flash_data_sel(flash_data_sel),
    .flash_rdata(flash_rdata), .primary_operand(primary_operand),
    .flags(flags), .stack_top(stack_top),
    .data_pointer_pair(data_pointer_pair)
);

// *** dv/flash_model.sv ***
`timescale 1ns/10ps
module flash_model (
    // Clock
    input wire logic        clk_sys,
    // Read port
    input wire logic [15:0] flash_addr,
    output logic     [7:0]  flash_rdata
);
    // Data lands one edge after the address; pattern mixes both halves
    always_ff @(posedge clk_sys) begin
        flash_rdata <= flash_addr[7:0] ^ flash_addr[15:8] ^ 8'h3c;
    end
endmodule

// *** dv/cpu_data_memory_map_test.sv ***
`timescale 1ns/10ps
module cpu_data_memory_map_test;
    import data_map_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    req_t        req = '0;
    logic        req_ready;
    rsp_t        rsp;
    logic        opcode_valid = 1'b0;
    logic [7:0]  opcode = 8'h00;
    alu_upd_t    alu_upd = '0;
    logic [15:0] fetch_pc = 16'h0000;
    logic [15:0] flash_addr;
    logic [7:0]  flash_rdata;
    logic [7:0]  primary_operand, muldiv_operand, flags, stack_top, r, v;
    logic [15:0] data_pointer_pair;
    logic [15:0] ret = 16'h0000;
    logic [9:0]  notes[$];
    logic [9:0]  note;
    int          error_cnt = 0;
    int          checks = 0;
    int          seed = 32'h93c2;
    int          i;

    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) fetch_pc <= 16'($random(seed));

    data_memory_map dut (.clk_sys(clk_sys), .rst(rst), .req(req),
        .req_ready(req_ready), .rsp(rsp), .opcode_valid(opcode_valid),
        .opcode(opcode), .alu_upd(alu_upd), .fetch_pc(fetch_pc),
        .flash_addr(flash_addr), .flash_prog_sel(), .flash_data_sel(),
        .flash_rdata(flash_rdata), .primary_operand(primary_operand),
        .muldiv_operand(muldiv_operand),
        .flags(flags), .stack_top(stack_top),
        .data_pointer_pair(data_pointer_pair));
    flash_model u_flash (.clk_sys(clk_sys), .flash_addr(flash_addr),
        .flash_rdata(flash_rdata));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Mode 1 compares read data, mode 2 the bit, mode 0 nothing
    task automatic op(input op_t o, input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] m, input logic [7:0] e);
        int n;
        n = 0;
        notes.push_back({m, e});
        req <= '{1'b1, o, a, d, d[0], ret};
        do @(posedge clk_sys); while (req_ready !== 1'b1 && ++n < 20);
        req.valid <= 1'b0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (rsp.valid !== 1'b1 && n < 40);
        if (n >= 40) begin
            error_cnt++;
            summarize();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        op(op_dir_wr, a, d, 2'd0, 8'h00);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        op(op_dir_rd, a, 8'h00, 2'd1, e);
    endtask
    task automatic dec(input logic [7:0] c);
        opcode_valid <= 1'b1;
        opcode <= c;
        @(posedge clk_sys);
        opcode_valid <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Answers are matched in order against the oldest expectation
    always @(posedge clk_sys) begin
        if (rsp.valid === 1'b1 && notes.size() > 0) begin
            note = notes.pop_front();
            if (note[9:8] == 2'd1)
                check({8'h00, rsp.rdata}, {8'h00, note[7:0]});
            if (note[9:8] == 2'd2)
                check({15'h0, rsp.rbit}, {15'h0, note[0]});
        end
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        check({8'h00, stack_top}, 16'h0007);
        check(data_pointer_pair, 16'h0000);
        for (i = 0; i < 8; i++) begin
            v = 8'($random(seed)) & 8'h7f;
            r = 8'($random(seed));
            wr(v, r);
            rd(v, r);
        end
        $display("test reset and ram done");
        for (i = 0; i < 4; i++) begin
            wr(8'hd0, 8'(i << 3));
            op(op_reg_wr, 8'h00, 8'hc0 + 8'(i), 2'd0, 8'h00);
            op(op_reg_wr, 8'h01, 8'h40 + 8'(i), 2'd0, 8'h00);
        end
        for (i = 0; i < 4; i++) begin
            r = 8'($random(seed));
            wr(8'hd0, 8'(i << 3));
            op(op_reg_rd, 8'h00, 8'h00, 2'd1, 8'hc0 + 8'(i));
            op(op_ind_wr, 8'h00, r, 2'd0, 8'h00);
            op(op_ind_rd, 8'h00, 8'h00, 2'd1, r);
            op(op_ind_wr, 8'h01, ~r, 2'd0, 8'h00);
            rd(8'h40 + 8'(i), ~r);
        end
        op(op_reg_wr, 8'h00, 8'he0, 2'd0, 8'h00);
        op(op_ind_wr, 8'h00, 8'h5a, 2'd0, 8'h00);
        wr(8'he0, 8'h33);
        op(op_ind_rd, 8'h00, 8'h00, 2'd1, 8'h5a);
        rd(8'he0, 8'h33);
        $display("test banks done");
        wr(8'h21, 8'h00);
        op(op_bit_wr, 8'h0b, 8'h01, 2'd0, 8'h00);
        rd(8'h21, 8'h08);
        op(op_bit_rd, 8'h0b, 8'h00, 2'd2, 8'h01);
        op(op_bit_wr, 8'he3, 8'h01, 2'd0, 8'h00);
        rd(8'he0, 8'h3b);
        op(op_bit_wr, 8'h8a, 8'h01, 2'd0, 8'h00);
        wr(8'h88, 8'hff);
        rd(8'h88, 8'h00);
        rd(8'h8f, 8'h00);
        $display("test bits done");
        r = 8'($random(seed));
        wr(8'h81, r);
        op(op_push, 8'h00, 8'ha1, 2'd0, 8'h00);
        op(op_push, 8'h00, 8'hb2, 2'd0, 8'h00);
        check({8'h00, stack_top}, {8'h00, r + 8'h02});
        op(op_pop, 8'h00, 8'h00, 2'd1, 8'hb2);
        op(op_pop, 8'h00, 8'h00, 2'd1, 8'ha1);
        check({8'h00, stack_top}, {8'h00, r});
        ret = 16'h1234;
        op(op_call, 8'h00, 8'h00, 2'd0, 8'h00);
        op(op_pop, 8'h00, 8'h00, 2'd1, 8'h12);
        op(op_pop, 8'h00, 8'h00, 2'd1, 8'h34);
        $display("test stack done");
        dec(8'ha4);
        dec(8'ha5);
        check(data_pointer_pair, 16'hffff);
        wr(8'ha3, 8'h01);
        wr(8'h82, 8'h10);
        dec(8'ha5);
        check(data_pointer_pair, 16'h000f);
        rd(8'ha3, 8'h01);
        wr(8'ha3, 8'h00);
        check(data_pointer_pair, 16'hffff);
        $display("test pointers done");
        wr(8'he0, 8'h05);
        wr(8'h82, 8'h00);
        wr(8'h83, 8'hf0);
        op(op_code_rd, 8'h00, 8'h00, 2'd1, 8'h05 ^ 8'hf0 ^ 8'h3c);
        wr(8'he0, 8'h10);
        wr(8'h83, 8'h00);
        op(op_code_rd, 8'h00, 8'h00, 2'd1, 8'h10 ^ 8'h3c);
        alu_upd <= '{1'b1, 8'h07, 1'b1, 8'h5a, 1'b1, 1'b1, 1'b0, 1'b1};
        @(posedge clk_sys);
        alu_upd <= '0;
        @(posedge clk_sys);
        rd(8'hf0, 8'h5a);
        check({8'h00, flags & 8'hc5}, 16'h0085);
        check({8'h00, muldiv_operand}, 16'h005a);
        check({8'h00, primary_operand}, 16'h0007);
        $display("test flash and alu done");
        summarize();
    end
endmodule
